// [core/hwu_pkg.sv]
// constants shared by the hci serial port with wake lines
// assumes a single 25 MHz clock and an active-low asynchronous reset
package hwu_pkg;

  // clock and baud generator
  localparam longint CLK_HZ = 25_000_000;
  localparam int ACC_BITS = 24;
  localparam longint OVERSAMPLE = 16;
  localparam longint BAUD_MIN_BPS = 115_200;
  localparam longint BAUD_MAX_BPS = 1_500_000;
  localparam longint BAUD_921K_BPS = 921_600;
  localparam longint BAUD_DEFAULT_BPS = 115_200;

  // phase increment for a rate, rounded to nearest so the error stays tiny
  localparam logic [63:0] INCR_MIN_W =
    (BAUD_MIN_BPS * OVERSAMPLE * (64'd1 << ACC_BITS) + CLK_HZ / 2) / CLK_HZ;
  localparam logic [63:0] INCR_921K_W =
    (BAUD_921K_BPS * OVERSAMPLE * (64'd1 << ACC_BITS) + CLK_HZ / 2) / CLK_HZ;
  localparam logic [63:0] INCR_MAX_W =
    (BAUD_MAX_BPS * OVERSAMPLE * (64'd1 << ACC_BITS) + CLK_HZ / 2) / CLK_HZ;
  localparam logic [63:0] INCR_DEF_W =
    (BAUD_DEFAULT_BPS * OVERSAMPLE * (64'd1 << ACC_BITS) + CLK_HZ / 2)
    / CLK_HZ;
  localparam logic [23:0] INCR_MIN = INCR_MIN_W[23:0];
  localparam logic [23:0] INCR_921K = INCR_921K_W[23:0];
  localparam logic [23:0] INCR_MAX = INCR_MAX_W[23:0];
  localparam logic [23:0] INCR_DEFAULT = INCR_DEF_W[23:0];

  // frame timing in oversample ticks
  localparam logic [3:0] TICK_MID = 4'h7;
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // buffer depths
  localparam int HCI_FIFO_DEPTH = 1040;
  localparam int PERIPH_FIFO_DEPTH = 256;
  localparam int RTS_MARGIN = 16;

  // pin routing
  localparam int GPIO_COUNT = 40;

  // line states
  typedef enum logic [1:0] {
    HWU_IDLE = 2'b00,
    HWU_START = 2'b01,
    HWU_DATA = 2'b10,
    HWU_STOP = 2'b11
  } hwu_line_type;

endpackage : hwu_pkg

// [core/hwu_uart.sv]
// byte fifo and the hci serial port with flow control and wake lines
// assumes pins synchronous to mclk; the peripheral instance sets DEPTH
`timescale 1ns/1ps
`default_nettype none

module hwu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // fill side
  input wire logic in_valid,
  output var logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side, registered output stage
  output var logic out_valid,
  input wire logic out_ready,
  output var logic [WIDTH-1:0] out_data,
  // fill level of the array, output stage not counted
  output var logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic push;
  logic pop;
  logic [CW-1:0] next_level;

  // pop into the output stage whenever it is empty or being drained
  assign push = in_valid && in_ready;
  assign pop = (level != '0) && (!out_valid || out_ready);

  always_comb
  begin
    next_level = level;
    if (push && !pop)
      next_level = level + CW'(1);
    else if (pop && !push)
      next_level = level - CW'(1);
  end

  // array write, no reset needed on storage
  always_ff @(posedge mclk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // pointers, level and full flag
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      level <= '0;
      in_ready <= 1'b0;
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PW'(1);
      if (pop)
        rd_ptr <= (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PW'(1);
      level <= next_level;
      in_ready <= (next_level != CNT_FULL);
    end
  end

  // output stage
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_valid <= 1'b0;
      out_data <= '0;
    end
    else if (pop)
    begin
      out_valid <= 1'b1;
      out_data <= mem[rd_ptr];
    end
    else if (out_ready)
      out_valid <= 1'b0;
  end

  a_level_bound: assert property (@(posedge mclk) disable iff (!reset_n) // R6
    level <= CNT_FULL)
    else $error("fifo level above depth");

endmodule : hwu_fifo

// Contract
// R1 - The port has receive, transmit, request-to-send and clear-to-send; each side drives its own outputs and watches the other's.
// R2 - The baud rate is programmable anywhere between 115200 bps and 1.5 Mbps.
// R3 - The generator produces 115200, 921600 and 1500000 bps as common points.
// R4 - The rate may be changed during operation when the host asks, by loading a new divisor.
// R5 - Reception works while the combined rate error of both ends stays within 5 percent.
// R6 - Received and sent bytes pass through separate 1040-byte fifos.
// R7 - Traffic is H4 framed, each packet led by its type byte, carried in byte order.
// R8 - After reset the port runs at 115.2 kbaud until a change is commanded.
// R9 - The host drives the device wake input; asserted wakes, released lets the device sleep when radio allows.
// R10 - The device drives the host wake output, asserting it when it needs the host.
// R11 - Both wake lines stay inactive until an enabling command is given.
// R12 - The peripheral instance behaves the same but with 256-byte fifos.
// R13 - The peripheral instance's signals may each be routed to any pin 0 to 39.
// R14 - Request-to-send drops near receive full, sending pauses while clear-to-send is off, frames are 8N1.
module hwu_uart #(
  parameter int FIFO_DEPTH = hwu_pkg::HCI_FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // dedicated serial pins
  input wire logic rx_in,
  output var logic tx_out,
  input wire logic cts_n_in,
  output var logic rts_n_out,
  // pin routing for the peripheral instance
  input wire logic route_en,
  input wire logic [5:0] rx_pin_sel,
  input wire logic [5:0] cts_pin_sel,
  input wire logic [5:0] tx_pin_sel,
  input wire logic [5:0] rts_pin_sel,
  input wire logic [39:0] gpio_in,
  output var logic [39:0] gpio_out,
  output var logic [39:0] gpio_oe,
  // rate control
  input wire logic [23:0] baud_incr,
  input wire logic baud_load,
  // bytes to send
  input wire logic tx_valid,
  output var logic tx_ready,
  input wire logic [7:0] tx_data,
  // bytes received
  output var logic rx_valid,
  input wire logic rx_ready,
  output var logic [7:0] rx_data,
  // line errors, one-cycle pulses
  output var logic frame_error,
  output var logic rx_overrun,
  // wake lines
  input wire logic wake_enable,
  input wire logic device_wake_in,
  input wire logic radio_idle,
  input wire logic host_wake_req,
  output var logic host_wake_out,
  output var logic device_awake,
  output var logic sleep_allowed
);
  localparam int CW = $clog2(FIFO_DEPTH+1);
  localparam logic [CW-1:0] RTS_LEVEL = CW'(FIFO_DEPTH - hwu_pkg::RTS_MARGIN);

  logic [23:0] incr;
  logic [23:0] acc;
  logic tick;
  logic [24:0] acc_sum;
  logic [23:0] next_incr;
  logic rx_line;
  logic cts_line;
  hwu_pkg::hwu_line_type rx_state;
  hwu_pkg::hwu_line_type tx_state;
  logic [3:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_push;
  logic [7:0] rx_byte;
  logic rxf_ready;
  logic [CW-1:0] rx_level;
  logic [3:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [7:0] tx_shift;
  logic txf_valid;
  logic [7:0] txf_data;
  logic tx_pop;

  // requested rate is clamped into the supported range
  always_comb
  begin
    next_incr = baud_incr; // R2
    if (baud_incr < hwu_pkg::INCR_MIN)
      next_incr = hwu_pkg::INCR_MIN;
    else if (baud_incr > hwu_pkg::INCR_MAX)
      next_incr = hwu_pkg::INCR_MAX;
  end

  // rate register; a change takes effect on the next tick, mid-frame too
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      incr <= hwu_pkg::INCR_DEFAULT; // R8
    else if (baud_load)
      incr <= next_incr; // R4
  end

  // fractional accumulator keeps every rate within a few ppm, far inside
  // the shared tolerance, at the cost of one cycle of tick jitter
  assign acc_sum = {1'b0, acc} + {1'b0, incr}; // R3 R5
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      acc <= '0;
      tick <= 1'b0;
    end
    else
    begin
      acc <= acc_sum[23:0];
      tick <= acc_sum[24];
    end
  end

  // input selection; an out-of-range pin reads as an idle line
  always_comb
  begin
    rx_line = rx_in;
    cts_line = cts_n_in;
    if (route_en)
    begin
      rx_line = (rx_pin_sel < 6'(hwu_pkg::GPIO_COUNT)) ?
        gpio_in[rx_pin_sel] : 1'b1; // R13
      cts_line = (cts_pin_sel < 6'(hwu_pkg::GPIO_COUNT)) ?
        gpio_in[cts_pin_sel] : 1'b1; // R13
    end
  end

  // receiver: start bit checked at mid-bit, data sampled at bit centres
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rx_state <= hwu_pkg::HWU_IDLE;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_shift <= '0;
      rx_push <= 1'b0;
      rx_byte <= '0;
      frame_error <= 1'b0;
    end
    else
    begin
      rx_push <= 1'b0;
      frame_error <= 1'b0;
      if (tick)
      begin
        rx_cnt <= rx_cnt + 4'h1;
        unique case (rx_state)
          hwu_pkg::HWU_IDLE:
          begin
            rx_cnt <= '0;
            if (!rx_line)
              rx_state <= hwu_pkg::HWU_START; // R1
          end
          hwu_pkg::HWU_START:
          begin
            if (rx_cnt == hwu_pkg::TICK_MID)
            begin
              rx_cnt <= '0;
              rx_bit <= '0;
              rx_state <= rx_line ? hwu_pkg::HWU_IDLE : hwu_pkg::HWU_DATA;
            end
          end
          hwu_pkg::HWU_DATA:
          begin
            if (rx_cnt == hwu_pkg::TICK_LAST)
            begin
              rx_shift <= {rx_line, rx_shift[7:1]}; // R14
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == hwu_pkg::BIT_LAST)
                rx_state <= hwu_pkg::HWU_STOP;
            end
          end
          hwu_pkg::HWU_STOP:
          begin
            if (rx_cnt == hwu_pkg::TICK_LAST)
            begin
              rx_state <= hwu_pkg::HWU_IDLE;
              rx_push <= rx_line;
              rx_byte <= rx_shift; // R7
              frame_error <= !rx_line; // R14
            end
          end
        endcase
      end
    end
  end

  // a byte arriving into a full buffer is dropped and reported
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rx_overrun <= 1'b0;
    else
      rx_overrun <= rx_push && !rxf_ready;
  end

  hwu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo ( // R6 R12
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(rx_push),
    .in_ready(rxf_ready),
    .in_data(rx_byte),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data(rx_data),
    .level(rx_level)
  );

  hwu_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo ( // R6 R12
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .in_data(tx_data),
    .out_valid(txf_valid),
    .out_ready(tx_pop),
    .out_data(txf_data),
    .level()
  );

  // a new frame starts only while the far end grants clear-to-send;
  // a frame under way is always finished
  assign tx_pop = (tx_state == hwu_pkg::HWU_IDLE) && txf_valid
    && !cts_line; // R14

  // transmitter, lsb first, one stop bit
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tx_state <= hwu_pkg::HWU_IDLE;
      tx_cnt <= '0;
      tx_bit <= '0;
      tx_shift <= '0;
      tx_out <= 1'b1;
    end
    else if (tx_pop)
    begin
      tx_state <= hwu_pkg::HWU_START;
      tx_shift <= txf_data; // R7
      tx_cnt <= '0;
      tx_out <= 1'b0; // R1
    end
    else if (tick && tx_state != hwu_pkg::HWU_IDLE)
    begin
      tx_cnt <= tx_cnt + 4'h1;
      if (tx_cnt == hwu_pkg::TICK_LAST)
      begin
        unique case (tx_state)
          hwu_pkg::HWU_IDLE:
            tx_out <= 1'b1;
          hwu_pkg::HWU_START:
          begin
            tx_state <= hwu_pkg::HWU_DATA;
            tx_bit <= '0;
            tx_out <= tx_shift[0];
          end
          hwu_pkg::HWU_DATA:
          begin
            tx_bit <= tx_bit + 3'h1;
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_out <= (tx_bit == hwu_pkg::BIT_LAST) ? 1'b1 : tx_shift[1];
            if (tx_bit == hwu_pkg::BIT_LAST)
              tx_state <= hwu_pkg::HWU_STOP; // R14
          end
          hwu_pkg::HWU_STOP:
            tx_state <= hwu_pkg::HWU_IDLE;
        endcase
      end
    end
  end

  // request-to-send is withdrawn with margin, since the far end may still
  // have a few bytes in flight
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      rts_n_out <= 1'b1;
    else
      rts_n_out <= (rx_level >= RTS_LEVEL); // R14
  end

  // routed outputs; pins not selected stay undriven
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gpio_out <= '0;
      gpio_oe <= '0;
    end
    else
    begin
      for (int i = 0; i < hwu_pkg::GPIO_COUNT; i++)
      begin
        gpio_oe[i] <= route_en && (tx_pin_sel == 6'(i)
          || rts_pin_sel == 6'(i)); // R13
        gpio_out[i] <= (tx_pin_sel == 6'(i)) ? tx_out :
          ((rts_pin_sel == 6'(i)) ? rts_n_out : 1'b0);
      end
    end
  end

  // wake lines ignored until enabled; disabled means always awake
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      host_wake_out <= 1'b0;
      device_awake <= 1'b1;
      sleep_allowed <= 1'b0;
    end
    else
    begin
      host_wake_out <= wake_enable && host_wake_req; // R10 R11
      device_awake <= !wake_enable || device_wake_in; // R9 R11
      sleep_allowed <= wake_enable && !device_wake_in && radio_idle; // R9
    end
  end

  a_rate_default: assert property (@(posedge mclk) disable iff (!reset_n) // R8
    $past(!reset_n) |-> incr == hwu_pkg::INCR_DEFAULT)
    else $error("rate not default after reset");

  a_rate_range: assert property (@(posedge mclk) disable iff (!reset_n) // R2
    incr >= hwu_pkg::INCR_MIN && incr <= hwu_pkg::INCR_MAX)
    else $error("rate outside supported range");

  a_rate_change: assert property (@(posedge mclk) disable iff (!reset_n) // R3
    baud_load && baud_incr == hwu_pkg::INCR_921K
    |=> incr == hwu_pkg::INCR_921K ##1 $stable(incr) || baud_load)
    else $error("rate change not applied");

  a_rts_full: assert property (@(posedge mclk) disable iff (!reset_n) // R14
    rx_level >= RTS_LEVEL |=> rts_n_out)
    else $error("rts still granted near full");

  a_cts_pause: assert property (@(posedge mclk) disable iff (!reset_n) // R14
    tx_state == hwu_pkg::HWU_IDLE && cts_line
    |=> tx_state == hwu_pkg::HWU_IDLE && tx_out)
    else $error("frame started without cts");

  a_start_bit: assert property (@(posedge mclk) disable iff (!reset_n) // R1
    tx_pop |=> !tx_out [*2])
    else $error("start bit missing");

  a_wake_off: assert property (@(posedge mclk) disable iff (!reset_n) // R11
    !wake_enable |=> !host_wake_out && device_awake && !sleep_allowed)
    else $error("wake lines active while disabled");

  a_host_wake: assert property (@(posedge mclk) disable iff (!reset_n) // R10
    wake_enable && host_wake_req |=> host_wake_out)
    else $error("host wake not asserted");

  a_sleep_gate: assert property (@(posedge mclk) disable iff (!reset_n) // R9
    sleep_allowed |-> $past(radio_idle) && !$past(device_wake_in))
    else $error("sleep allowed while woken or radio busy");

  a_frame_err: assert property (@(posedge mclk) disable iff (!reset_n) // R14
    frame_error |-> !rx_push && $past(rx_state) == hwu_pkg::HWU_STOP)
    else $error("frame error outside stop bit");

endmodule : hwu_uart

`default_nettype wire

// [core/hwu_uart_unused_placeholder_none.sv]
// intentionally holds nothing: all logic lives in hwu_uart.sv
// assumes nothing
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// [tb/hwu_host_model.sv]
// host end of the serial link: sends 8n1 frames and collects the device's
// assumes the bench keeps bit_ns equal to the device's current bit time
`timescale 1ns/1ps
`default_nettype none
module hwu_host_model (
  // lines from the device
  input wire logic line_in,
  input wire logic rts_n,
  // lines to the device
  output var logic line_out,
  output var logic cts_n
);
  real bit_ns = 8680.0;
  logic [7:0] got_q[$];
  int stop_bad = 0;
  // cleared only to provoke an overrun on purpose
  logic obey_rts = 1'b1;

  // idle line high; cts low so the device may send at once
  initial
  begin
    line_out = 1'b1;
    cts_n = 1'b0;
  end

  // one frame lsb first; a low stop bit is only used to provoke errors
  task automatic send(input logic [7:0] b, input logic stop);
    while (obey_rts && rts_n !== 1'b0)
      #(bit_ns);
    line_out = 1'b0;
    #(bit_ns);
    for (int i = 0; i < 8; i++)
    begin
      line_out = b[i];
      #(bit_ns);
    end
    line_out = stop;
    #(bit_ns);
    line_out = 1'b1;
    #(bit_ns);
  endtask : send

  // mid-bit sampling tolerates small rate error on either side
  always
  begin : receiver
    logic [7:0] b;
    @(negedge line_in);
    #(bit_ns / 2.0);
    if (line_in === 1'b0)
    begin
      for (int i = 0; i < 8; i++)
      begin
        #(bit_ns);
        b[i] = line_in;
      end
      #(bit_ns);
      if (line_in === 1'b1) got_q.push_back(b);
      else stop_bad++;
    end
  end
endmodule : hwu_host_model
`default_nettype wire

// [tb/hci_uart_with_wake_bench.sv]
// self-checking bench for the hci serial port, queues model both directions
// assumes the host model is compiled first and mclk runs at 25 MHz
`timescale 1ns/1ps
`default_nettype none
module hci_uart_with_wake_bench;
  localparam int DEPTH = 20;
  logic mclk, reset_n, route_en, baud_load, tx_valid, rx_ready;
  logic tx_out, rts_n_out, tx_ready, rx_valid, frame_error, rx_overrun;
  logic wake_enable, device_wake_in, radio_idle, host_wake_req;
  logic host_wake_out, device_awake, sleep_allowed, host_line, host_cts;
  logic dev_tx, host_rts;
  logic [5:0] rx_sel, cts_sel, tx_sel, rts_sel;
  logic [39:0] gpio_in, gpio_out, gpio_oe;
  logic [23:0] baud_incr;
  logic [7:0] tx_data, rx_data;
  logic [7:0] exp_rx[$], exp_tx[$];
  logic [31:0] seed = 32'hf9c2_df30;
  int err_total = 0, comparisons = 0, cycles = 0, fe_cnt = 0, ov_cnt = 0;

  hwu_uart #(.FIFO_DEPTH(DEPTH)) uut (
    .mclk(mclk), .reset_n(reset_n), .rx_in(host_line), .tx_out(tx_out),
    .cts_n_in(host_cts), .rts_n_out(rts_n_out), .route_en(route_en),
    .rx_pin_sel(rx_sel), .cts_pin_sel(cts_sel), .tx_pin_sel(tx_sel),
    .rts_pin_sel(rts_sel), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .baud_incr(baud_incr), .baud_load(baud_load),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
    .frame_error(frame_error), .rx_overrun(rx_overrun),
    .wake_enable(wake_enable), .device_wake_in(device_wake_in),
    .radio_idle(radio_idle), .host_wake_req(host_wake_req),
    .host_wake_out(host_wake_out), .device_awake(device_awake),
    .sleep_allowed(sleep_allowed)
  );
  hwu_host_model host (.line_in(dev_tx), .rts_n(host_rts),
    .line_out(host_line), .cts_n(host_cts));

  // free-running clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // routed pins: host sees the selected output, unselected inputs read high
  assign dev_tx = route_en ? gpio_out[tx_sel] : tx_out;
  assign host_rts = route_en ? gpio_out[rts_sel] : rts_n_out;
  always_comb
  begin
    gpio_in = {40{1'b1}};
    if (rx_sel < 6'd40) gpio_in[rx_sel] = host_line;
    if (cts_sel < 6'd40) gpio_in[cts_sel] = host_cts;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  function automatic real bitns(input logic [23:0] inc);
    return 16.0 * 16777216.0 * 40.0 / inc;
  endfunction : bitns

  task automatic check(input logic [39:0] seen, input logic [39:0] want,
                       input string what);
    comparisons++;
    if (seen !== want)
    begin
      err_total++;
      $display("MISMATCH %0t %s: got %h want %h", $time, what, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    if (err_total == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : tally_and_finish

  // the model's bit time follows the increment that the device really uses
  task automatic set_rate(input logic [23:0] inc, input logic [23:0] eff);
    @(negedge mclk);
    baud_incr = inc;
    baud_load = 1'b1;
    @(negedge mclk);
    baud_load = 1'b0;
    host.bit_ns = bitns(eff);
  endtask : set_rate

  // holds valid and data until the edge that sees ready high
  task automatic put_byte(input logic [31:0] b);
    int n;
    n = 0;
    @(negedge mclk);
    tx_valid = 1'b1;
    tx_data = b[7:0];
    exp_tx.push_back(b[7:0]);
    while (tx_ready !== 1'b1 && n < 5000)
    begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    // valid drops at the next falling edge, before another rising edge, so a lone byte is never pushed twice
    @(negedge mclk);
    tx_valid = 1'b0;
  endtask : put_byte

  task automatic host_put(input logic [31:0] b);
    exp_rx.push_back(b[7:0]);
    host.send(b[7:0], 1'b1);
  endtask : host_put

  task automatic drain_host();
    int n;
    n = 0;
    @(negedge mclk);
    tx_valid = 1'b0;
    while (host.got_q.size() < exp_tx.size() && n < 20000)
    begin
      @(negedge mclk);
      n++;
    end
    check(host.got_q.size(), exp_tx.size(), "host count");
    while (exp_tx.size() > 0 && host.got_q.size() > 0)
      check(host.got_q.pop_front(), exp_tx.pop_front(), "host byte");
  endtask : drain_host

  // one byte each way at once; the device's byte is compared as it is handed out, then the host's side
  task automatic swap_one();
    fork
      host_put(xs());
      put_byte(xs());
    join
    drain_host();
  endtask : swap_one

  // handed-out bytes match in order; pulses are counted once each
  always @(negedge mclk)
  begin
    #1;
    if (reset_n === 1'b1 && rx_valid === 1'b1 && rx_ready === 1'b1)
    begin
      if (exp_rx.size() == 0) check(1, 0, "unexpected byte");
      else check(rx_data, exp_rx.pop_front(), "rx byte");
    end
    if (frame_error === 1'b1) fe_cnt++;
    if (rx_overrun === 1'b1) ov_cnt++;
  end

  // a hang ends the run after well over the expected 15k cycles
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_total++;
      tally_and_finish();
    end
  end

  initial
  begin
    logic [31:0] r;
    int n;
    reset_n = 1'b0;
    {route_en, baud_load, tx_valid, tx_data} = '0;
    {wake_enable, device_wake_in, radio_idle, host_wake_req} = 4'h0;
    {rx_sel, cts_sel, tx_sel, rts_sel} = {4{6'h3f}};
    baud_incr = hwu_pkg::INCR_DEFAULT;
    rx_ready = 1'b1;
    repeat (6) @(negedge mclk);
    check({tx_out, rts_n_out, tx_ready, device_awake, host_wake_out},
      5'b1_1010, "reset outputs");
    reset_n = 1'b1;
    repeat (2) @(negedge mclk);
    check({rts_n_out, tx_ready}, 2'b01, "after reset");
    check(gpio_oe, 40'h0, "oe unrouted");
    swap_one();
    // 921600, a random intermediate increment, then an over-range one
    for (int k = 0; k < 3; k++)
    begin
      r = hwu_pkg::INCR_MIN + xs() % (hwu_pkg::INCR_MAX - hwu_pkg::INCR_MIN);
      if (k == 0) set_rate(hwu_pkg::INCR_921K, hwu_pkg::INCR_921K);
      if (k == 1) set_rate(r[23:0], r[23:0]);
      if (k == 2) set_rate(24'hff_ffff, hwu_pkg::INCR_MAX);
      swap_one();
    end
    // host runs 3 percent slow, inside the shared tolerance
    host.bit_ns = bitns(hwu_pkg::INCR_MAX) * 1.03;
    swap_one();
    host.bit_ns = bitns(hwu_pkg::INCR_MAX);
    fork
      for (int i = 0; i < 8; i++) host_put(xs());
      for (int i = 0; i < 8; i++) put_byte(xs());
    join
    drain_host();
    // far side stalls: the send buffer fills until it refuses
    host.cts_n = 1'b1;
    n = 0;
    for (int i = 0; i < 40; i++)
    begin
      @(negedge mclk);
      if (tx_ready !== 1'b1) break;
      r = xs();
      tx_valid = 1'b1;
      tx_data = r[7:0];
      exp_tx.push_back(r[7:0]);
      n++;
    end
    tx_valid = 1'b0;
    check(n, DEPTH + 1, "send capacity");
    r = 0;
    repeat (200) @(negedge mclk) if (tx_out !== 1'b1) r++;
    check(r, 0, "line quiet in stall");
    host.cts_n = 1'b0;
    drain_host();
    host.send(8'h5a, 1'b0);
    check(fe_cnt, 1, "frame error");
    // receive side fills: rts rises at the margin, one extra is dropped;
    // the host ignores rts here only so that the overrun can be provoked
    host.obey_rts = 1'b0;
    @(negedge mclk);
    rx_ready = 1'b0;
    for (int i = 0; i < DEPTH + 2; i++)
    begin
      r = xs();
      if (i <= DEPTH) exp_rx.push_back(r[7:0]);
      host.send(r[7:0], 1'b1);
      check(rts_n_out, i >= DEPTH - hwu_pkg::RTS_MARGIN, "rts level");
    end
    check(ov_cnt, 1, "overrun");
    @(negedge mclk);
    rx_ready = 1'b1;
    host.obey_rts = 1'b1;
    repeat (100) @(negedge mclk);
    check({rts_n_out, 8'(exp_rx.size())}, 9'h0, "drained");
    // pins routed to random places
    // selects settle first, so the routed transmit pin already idles high
    r = xs() % 37;
    rx_sel = r[5:0];
    cts_sel = r[5:0] + 6'd1;
    tx_sel = r[5:0] + 6'd2;
    rts_sel = r[5:0] + 6'd3;
    repeat (2) @(negedge mclk);
    route_en = 1'b1;
    repeat (2) @(negedge mclk);
    check(gpio_oe, (40'd1 << tx_sel) | (40'd1 << rts_sel), "oe");
    check({gpio_out[tx_sel], gpio_out[rts_sel]}, 2'b10, "pins idle");
    swap_one();
    for (int i = 0; i < 12; i++)
    begin
      r = xs();
      @(negedge mclk);
      {wake_enable, device_wake_in, radio_idle, host_wake_req} = r[3:0];
      @(negedge mclk);
      check({host_wake_out, device_awake, sleep_allowed},
        {r[3] & r[0], ~r[3] | r[2], r[3] & ~r[2] & r[1]},
        "wake");
    end
    check(host.stop_bad, 0, "host stop bits");
    tally_and_finish();
  end
endmodule : hci_uart_with_wake_bench
`default_nettype wire
